/* File: src/cgd_clock_ctrl.sv */
// Clock source select, divide and delayed gate request for the intc and peripheral clocks
// Functional notes
// - Top control byte holds gate entry delay, 0 to 255 cycles before gate request.
// - Low control byte selects source: 0 gated, 1 reference clock, 2 PLL (intc PLL for intc, system PLL for peripheral).
// - Bits 15:8 report the source in use, only ever 0, 1 or 2.
// - Divider request field value plus one is the requested division ratio.
// - Bits 20:16 read back the ratio in use, minus one.
// - Divider ratio applies to the PLL source, select encoding two.
// - Intc clock divides its dedicated PLL input; divider in use reads back.
//
// The APB interface to the registers was decided locally.
module cgd_clock_ctrl (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        REFERENCE_CLOCK,
	input  wire logic        SYSTEM_PLL_CLOCK,
	input  wire logic        INTC_PLL_CLOCK,
	input  wire logic [1:0]  CLK_REQUIRED,
	output logic             INTC_CLOCK_EN,
	output logic             PERIPHERAL_CLOCK_EN,
	output logic [1:0]       GATE_REQUEST
);
	cgd_pkg::cgd_state_type r;
	cgd_pkg::cgd_state_type n;
	logic [2:0]  tick;
	logic        setup_ph;
	logic        wr_acc;
	logic        mapped;

	assign setup_ph = PSEL && !PENABLE;
	assign wr_acc   = PSEL && PENABLE && PWRITE;
	assign mapped   = (PADDR == cgd_pkg::INTC_CTRL_OFS) || (PADDR == cgd_pkg::INTC_DIV_OFS) ||
	                  (PADDR == cgd_pkg::PERI_CTRL_OFS) || (PADDR == cgd_pkg::PERI_DIV_OFS);
	// Edge of a synchronised source marks one source period; the first stage feeds only the second
	assign tick     = r.sy2[2:0] & ~r.sy3;

	always_comb begin
		logic        pll_tick;
		logic        req;
		logic        en;
		logic [31:0] rd;
		pll_tick = 1'b0;
		req      = 1'b0;
		en       = 1'b0;
		rd       = 32'h0000_0000;
		n        = r;
		n.sy1    = {CLK_REQUIRED, INTC_PLL_CLOCK, SYSTEM_PLL_CLOCK, REFERENCE_CLOCK};
		n.sy2    = r.sy1;
		n.sy3    = r.sy2[2:0];
		for (int i = 0; i < 2; i++) begin
			// Intc channel divides its own PLL, the peripheral channel the system PLL
			pll_tick = (i == cgd_pkg::CH_INTC) ? tick[2] : tick[1];
			req      = r.sy2[3 + i];
			en       = 1'b0;
			// A reserved choice leaves the source in use untouched
			if (r.ch[i].sel <= cgd_pkg::SEL_PLL) begin
				n.ch[i].selcur = r.ch[i].sel;
			end
			if (r.ch[i].selcur == cgd_pkg::SEL_PLL) begin
				if (pll_tick) begin
					if (r.ch[i].divcnt == r.ch[i].divcur) begin
						en              = 1'b1;
						n.ch[i].divcnt  = 5'h00;
						// New ratio only at a period boundary, so no runt pulse
						n.ch[i].divcur  = r.ch[i].divreq;
					end else begin
						n.ch[i].divcnt = r.ch[i].divcnt + 5'h01;
					end
				end
			end else begin
				n.ch[i].divcur = r.ch[i].divreq;
				n.ch[i].divcnt = 5'h00;
			end
			case (r.ch[i].selcur)
				cgd_pkg::SEL_REF: en = tick[0];
				cgd_pkg::SEL_PLL: en = en;
				default:          en = 1'b0;
			endcase
			n.ch[i].clk_en = en && (r.ch[i].gst != cgd_pkg::GS_GATED);
			case (r.ch[i].gst)
				cgd_pkg::GS_RUN: begin
					if (!req) begin
						n.ch[i].dlycnt = 8'h01;
						n.ch[i].gst    = (r.ch[i].dly == 8'h00) ? cgd_pkg::GS_GATED : cgd_pkg::GS_COUNT;
					end
				end
				cgd_pkg::GS_COUNT: begin
					if (req) begin
						n.ch[i].gst = cgd_pkg::GS_RUN;
					end else if (r.ch[i].dlycnt >= r.ch[i].dly) begin
						n.ch[i].gst = cgd_pkg::GS_GATED;
					end else begin
						n.ch[i].dlycnt = r.ch[i].dlycnt + 8'h01;
					end
				end
				cgd_pkg::GS_GATED: begin
					if (req) begin
						n.ch[i].gst = cgd_pkg::GS_RUN;
					end
				end
				default: n.ch[i].gst = cgd_pkg::GS_RUN;
			endcase
		end
		if (wr_acc) begin
			case (PADDR)
				cgd_pkg::INTC_CTRL_OFS: begin
					n.ch[cgd_pkg::CH_INTC].sel = PWDATA[cgd_pkg::SEL_LSB +: 8];
					n.ch[cgd_pkg::CH_INTC].dly = PWDATA[cgd_pkg::DLY_LSB +: 8];
				end
				cgd_pkg::INTC_DIV_OFS:  n.ch[cgd_pkg::CH_INTC].divreq = PWDATA[cgd_pkg::DIVREQ_LSB +: 5];
				cgd_pkg::PERI_CTRL_OFS: begin
					n.ch[cgd_pkg::CH_PERI].sel = PWDATA[cgd_pkg::SEL_LSB +: 8];
					n.ch[cgd_pkg::CH_PERI].dly = PWDATA[cgd_pkg::DLY_LSB +: 8];
				end
				cgd_pkg::PERI_DIV_OFS:  n.ch[cgd_pkg::CH_PERI].divreq = PWDATA[cgd_pkg::DIVREQ_LSB +: 5];
				default: ;
			endcase
		end
		// Read data is captured in the setup cycle and stands through the access phase
		if (setup_ph) begin
			case (PADDR)
				cgd_pkg::INTC_CTRL_OFS, cgd_pkg::PERI_CTRL_OFS: begin
					rd[cgd_pkg::DLY_LSB +: 8]    = r.ch[PADDR[5]].dly;
					rd[cgd_pkg::SELCUR_LSB +: 8] = r.ch[PADDR[5]].selcur;
					rd[cgd_pkg::SEL_LSB +: 8]    = r.ch[PADDR[5]].sel;
				end
				cgd_pkg::INTC_DIV_OFS, cgd_pkg::PERI_DIV_OFS: begin
					rd[cgd_pkg::DIVCUR_LSB +: 5] = r.ch[PADDR[5]].divcur;
					rd[cgd_pkg::DIVREQ_LSB +: 5] = r.ch[PADDR[5]].divreq;
				end
				default: rd = 32'h0000_0000;
			endcase
			n.prdata = rd;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r        <= '0;
			// Required inputs leave reset as required, so release raises no false gate request
			r.sy1[4:3] <= 2'b11;
			r.sy2[4:3] <= 2'b11;
			for (int i = 0; i < 2; i++) begin
				r.ch[i].sel    <= cgd_pkg::SEL_RST;
				r.ch[i].dly    <= cgd_pkg::DLY_RST;
				r.ch[i].divreq <= cgd_pkg::DIVREQ_RST;
				r.ch[i].selcur <= cgd_pkg::SEL_RST;
				r.ch[i].divcur <= cgd_pkg::DIVREQ_RST;
				r.ch[i].gst    <= cgd_pkg::GS_RUN;
			end
		end else begin
			r <= n;
		end
	end

	assign PRDATA              = r.prdata;
	assign PREADY              = 1'b1;
	assign PSLVERR             = PSEL && PENABLE && !mapped;
	assign INTC_CLOCK_EN       = r.ch[cgd_pkg::CH_INTC].clk_en;
	assign PERIPHERAL_CLOCK_EN = r.ch[cgd_pkg::CH_PERI].clk_en;
	assign GATE_REQUEST[0]     = (r.ch[0].gst == cgd_pkg::GS_GATED);
	assign GATE_REQUEST[1]     = (r.ch[1].gst == cgd_pkg::GS_GATED);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// Register side: writes land only at the access edge, reads are captured at the setup edge

	chk_ref_source_pulse: assert property (
		(r.ch[1].selcur == cgd_pkg::SEL_REF && tick[0] && r.ch[1].gst != cgd_pkg::GS_GATED)
		|=> PERIPHERAL_CLOCK_EN)
		else $error("reference tick not passed to peripheral clock");

	chk_source_in_use_legal: assert property (
		r.ch[0].selcur <= cgd_pkg::SEL_PLL && r.ch[1].selcur <= cgd_pkg::SEL_PLL)
		else $error("source in use holds reserved value");

	chk_divider_write_store: assert property (
		(wr_acc && PADDR == cgd_pkg::PERI_DIV_OFS) |=> r.ch[1].divreq == $past(PWDATA[4:0]))
		else $error("divider request not stored");

	chk_intc_div_store: assert property (
		(wr_acc && PADDR == cgd_pkg::INTC_DIV_OFS) |=> r.ch[0].divreq == $past(PWDATA[4:0]))
		else $error("intc divider request not stored");

	chk_ctrl_write_store: assert property (
		(wr_acc && PADDR == cgd_pkg::PERI_CTRL_OFS)
		|=> (r.ch[1].dly == $past(PWDATA[31:24]) && r.ch[1].sel == $past(PWDATA[7:0])))
		else $error("peripheral control write not stored");

	chk_intc_ctrl_store: assert property (
		(wr_acc && PADDR == cgd_pkg::INTC_CTRL_OFS)
		|=> (r.ch[0].dly == $past(PWDATA[31:24]) && r.ch[0].sel == $past(PWDATA[7:0])))
		else $error("intc control write not stored");

	// A setup cycle alone must never disturb the stored source choice or divider request of either channel
	chk_setup_no_write: assert property (
		(PSEL && !PENABLE) |=> ($stable(r.ch[0].sel) && $stable(r.ch[1].sel) &&
		                        $stable(r.ch[0].divreq) && $stable(r.ch[1].divreq)))
		else $error("register changed without access phase");

	chk_divider_readback: assert property (
		(setup_ph && PADDR == cgd_pkg::INTC_DIV_OFS) |=> PRDATA[20:16] == $past(r.ch[0].divcur))
		else $error("divider in use read back wrong");

	chk_peri_div_readback: assert property (
		(setup_ph && PADDR == cgd_pkg::PERI_DIV_OFS)
		|=> (PRDATA[20:16] == $past(r.ch[1].divcur) && PRDATA[4:0] == $past(r.ch[1].divreq)))
		else $error("peripheral divider read back wrong");

	chk_ctrl_readback: assert property (
		(setup_ph && PADDR == cgd_pkg::PERI_CTRL_OFS)
		|=> PRDATA == {$past(r.ch[1].dly), 8'h00, $past(r.ch[1].selcur), $past(r.ch[1].sel)})
		else $error("peripheral control read back wrong");

	chk_intc_ctrl_readback: assert property (
		(setup_ph && PADDR == cgd_pkg::INTC_CTRL_OFS)
		|=> PRDATA == {$past(r.ch[0].dly), 8'h00, $past(r.ch[0].selcur), $past(r.ch[0].sel)})
		else $error("intc control read back wrong");

	chk_unmapped_read: assert property (
		(setup_ph && !mapped) |=> (PRDATA == 32'h0000_0000))
		else $error("unmapped read not zero");

	// Divider checks on the two PLL sources
	chk_pll_divide_pulse: assert property (
		(r.ch[1].selcur == cgd_pkg::SEL_PLL && tick[1] && r.ch[1].divcnt != r.ch[1].divcur)
		|=> !PERIPHERAL_CLOCK_EN)
		else $error("peripheral clock pulsed mid divide period");

	chk_intc_pll_divide: assert property (
		(r.ch[0].selcur == cgd_pkg::SEL_PLL && tick[2] && r.ch[0].divcnt == r.ch[0].divcur &&
		 r.ch[0].gst != cgd_pkg::GS_GATED) |=> INTC_CLOCK_EN)
		else $error("intc clock missing divided pulse");

	// Per channel: a helper counts the cycles the synchronised required level has been low,
	// so the gate delay is judged against the level the state machine really sees
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_chan
			logic [8:0] low_cnt;

			// Saturates above the largest delay, so a long idle stretch cannot wrap
			always_ff @(posedge CLK or negedge NRST) begin
				if (!NRST) begin
					low_cnt <= 9'h000;
				end else if (r.sy2[3 + g]) begin
					low_cnt <= 9'h000;
				end else if (low_cnt != 9'h1ff) begin
					low_cnt <= low_cnt + 9'h001;
				end
			end

			chk_gate_delay_count: assert property (@(posedge CLK) disable iff (!NRST)
				($rose(GATE_REQUEST[g]) && $stable(r.ch[g].dly))
				|-> (low_cnt == {1'b0, r.ch[g].dly} + 9'h001))
				else $error("gate request not after programmed delay");

			chk_gate_delay_zero: assert property (@(posedge CLK) disable iff (!NRST)
				(r.ch[g].gst == cgd_pkg::GS_RUN && !r.sy2[3 + g] && r.ch[g].dly == 8'h00) |=> GATE_REQUEST[g])
				else $error("zero delay did not gate at once");

			chk_gate_abandon: assert property (@(posedge CLK) disable iff (!NRST)
				(r.ch[g].gst == cgd_pkg::GS_COUNT && r.sy2[3 + g]) |=> !GATE_REQUEST[g] ##1 !GATE_REQUEST[g])
				else $error("gate count not abandoned");

			chk_gate_release: assert property (@(posedge CLK) disable iff (!NRST)
				(GATE_REQUEST[g] && r.sy2[3 + g]) |=> !GATE_REQUEST[g])
				else $error("gate request held while clock required");

			chk_gated_no_pulse: assert property (@(posedge CLK) disable iff (!NRST)
				GATE_REQUEST[g] |=> !r.ch[g].clk_en)
				else $error("clock pulse while gate requested");

			chk_gated_source_quiet: assert property (@(posedge CLK) disable iff (!NRST)
				(r.ch[g].selcur == cgd_pkg::SEL_GATED) [*2] |-> !r.ch[g].clk_en)
				else $error("gated source still pulses");

			// Reserved choices are not covered here: software never writes them
			chk_source_follows: assert property (@(posedge CLK) disable iff (!NRST)
				(r.ch[g].sel <= cgd_pkg::SEL_PLL) |=> (r.ch[g].selcur == $past(r.ch[g].sel)))
				else $error("source in use does not follow choice");

			chk_divider_follows: assert property (@(posedge CLK) disable iff (!NRST)
				(r.ch[g].selcur != cgd_pkg::SEL_PLL) |=> (r.ch[g].divcur == $past(r.ch[g].divreq)))
				else $error("divider in use does not follow request");

			chk_pulse_single: assert property (@(posedge CLK) disable iff (!NRST)
				r.ch[g].clk_en |=> !r.ch[g].clk_en)
				else $error("clock enable longer than one cycle");
		end
	endgenerate

	// Main scenarios: gating reached, divided pulses, abandoned count, PLL source running
	cov_gate_reached:  cover property ($rose(GATE_REQUEST[1]));
	cov_intc_divided:  cover property (r.ch[0].divcur != 5'h00 ##1 INTC_CLOCK_EN);
	cov_abandon:       cover property (r.ch[1].gst == cgd_pkg::GS_COUNT ##1 r.ch[1].gst == cgd_pkg::GS_RUN);
	cov_peri_pll:      cover property (r.ch[1].selcur == cgd_pkg::SEL_PLL && PERIPHERAL_CLOCK_EN);
endmodule : cgd_clock_ctrl

/* File: src/cgd_pkg.sv */
// Constants, field layout and state types of the clock gate, select and divide block
package cgd_pkg;
	localparam logic [11:0] INTC_CTRL_OFS = 12'h850;
	localparam logic [11:0] INTC_DIV_OFS  = 12'h854;
	localparam logic [11:0] PERI_CTRL_OFS = 12'h870;
	localparam logic [11:0] PERI_DIV_OFS  = 12'h874;

	localparam int DLY_LSB    = 24;
	localparam int SELCUR_LSB = 8;
	localparam int SEL_LSB    = 0;
	localparam int DIVCUR_LSB = 16;
	localparam int DIVREQ_LSB = 0;

	localparam logic [7:0] SEL_GATED = 8'h00;
	localparam logic [7:0] SEL_REF   = 8'h01;
	localparam logic [7:0] SEL_PLL   = 8'h02;

	localparam logic [7:0] SEL_RST    = 8'h01;
	localparam logic [7:0] DLY_RST    = 8'h00;
	localparam logic [4:0] DIVREQ_RST = 5'h1f;

	localparam int CH_INTC = 0;
	localparam int CH_PERI = 1;

	typedef enum logic [1:0] {
		GS_RUN   = 2'b00,
		GS_COUNT = 2'b01,
		GS_GATED = 2'b11
	} gate_state_type;

	typedef struct packed {
		logic [7:0]     sel;
		logic [7:0]     dly;
		logic [4:0]     divreq;
		logic [7:0]     selcur;
		logic [4:0]     divcur;
		logic [4:0]     divcnt;
		logic [7:0]     dlycnt;
		gate_state_type gst;
		logic           clk_en;
	} cgd_chan_type;

	// Sync bit order: 0 reference, 1 system PLL, 2 intc PLL, 4:3 clock required
	typedef struct packed {
		logic [4:0]            sy1;
		logic [4:0]            sy2;
		logic [2:0]            sy3;
		logic [31:0]           prdata;
		cgd_chan_type [1:0]    ch;
	} cgd_state_type;
endpackage : cgd_pkg

/* File: verif/tb_top.sv */
// Self-checking testbench for the clock gate, select and divide block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, psel, penable, pwrite, ref_c, sys_c, intc_c;
	logic [11:0] paddr, ctrl;
	logic [31:0] pwdata, prdata, w;
	logic        pready, pslverr, intc_en, peri_en;
	logic [1:0]  req, gate_r;
	logic [4:0]  d;
	logic [32:0] notes[$];
	int          miscompares, checks, cycles, seed, n0, n;

	cgd_clock_ctrl uut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.REFERENCE_CLOCK(ref_c), .SYSTEM_PLL_CLOCK(sys_c), .INTC_PLL_CLOCK(intc_c),
		.CLK_REQUIRED(req), .INTC_CLOCK_EN(intc_en), .PERIPHERAL_CLOCK_EN(peri_en), .GATE_REQUEST(gate_r));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Source clocks keep both phases at least two cycles long so the synchronisers see every edge
	always @(posedge clk) begin
		cycles++;
		ref_c  <= (cycles % 6) < 3;
		sys_c  <= (cycles % 8) < 4;
		intc_c <= (cycles % 10) < 5;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, notes.pop_front(), "read data");
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] exp);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		if (!wr)
			notes.push_back(exp);
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Cycles between the second and third enable pulse; 400 means no pulse came
	task automatic period(input int ch, output int p);
		for (int k = 0; k < 3; k++) begin
			p = 0;
			do begin
				@(posedge clk);
				p++;
			end while ((ch ? peri_en : intc_en) !== 1'b1 && p < 400);
		end
	endtask : period

	task automatic gate(input int ch, input logic [7:0] dly, input int hold, output int p);
		apb(1'b1, ch ? cgd_pkg::PERI_CTRL_OFS : cgd_pkg::INTC_CTRL_OFS, {dly, 16'h0, cgd_pkg::SEL_REF}, 33'h0);
		@(posedge clk);
		req[ch] <= 1'b0;
		p = 0;
		do begin
			@(posedge clk);
			p++;
			if (p == hold)
				req[ch] <= 1'b1;
		end while (gate_r[ch] !== 1'b1 && p < 400);
		req[ch] <= 1'b1;
		repeat (8) @(posedge clk);
		chk({32'h0, gate_r[ch]}, 33'h0, "gate release");
	endtask : gate

	task automatic print_verdict;
		$display("Counts: %0d checks, %0d miscompares", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	initial begin
		seed = 32'h22c1;
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		req = 2'b11;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int ch = 0; ch < 2; ch++) begin
			ctrl = ch ? cgd_pkg::PERI_CTRL_OFS : cgd_pkg::INTC_CTRL_OFS;
			apb(1'b0, ctrl, 32'h0, 33'h0_0000_0101);
			apb(1'b0, ctrl + 12'h4, 32'h0, 33'h0_001f_001f);
		end
		apb(1'b1, 12'h860, $random(seed), 33'h0);
		apb(1'b0, 12'h860, 32'h0, {1'b1, 32'h0});
		for (int s = 2; s >= 0; s--) begin
			w = $random(seed);
			apb(1'b1, cgd_pkg::PERI_CTRL_OFS, {w[31:8], 8'(s)}, 33'h0);
			apb(1'b0, cgd_pkg::PERI_CTRL_OFS, 32'h0, {1'b0, w[31:24], 8'h0, 8'(s), 8'(s)});
		end
		w = $random(seed);
		apb(1'b1, cgd_pkg::PERI_DIV_OFS, w, 33'h0);
		apb(1'b0, cgd_pkg::PERI_DIV_OFS, 32'h0, {12'h0, w[4:0], 11'h0, w[4:0]});
		$display("Test registers done");
		for (int ch = 0; ch < 2; ch++) begin
			ctrl = ch ? cgd_pkg::PERI_CTRL_OFS : cgd_pkg::INTC_CTRL_OFS;
			d = 5'($random(seed)) & 5'h3;
			apb(1'b1, ctrl, {24'h0, cgd_pkg::SEL_REF}, 33'h0);
			period(ch, n);
			chk(33'(n), 33'd6, "reference period");
			apb(1'b1, ctrl + 12'h4, {27'h0, d}, 33'h0);
			apb(1'b1, ctrl, {24'h0, cgd_pkg::SEL_PLL}, 33'h0);
			period(ch, n);
			chk(33'(n), 33'((d + 1) * (ch ? 8 : 10)), "divided period");
			apb(1'b0, ctrl + 12'h4, 32'h0, {12'h0, d, 11'h0, d});
			apb(1'b1, ctrl, {24'h0, cgd_pkg::SEL_GATED}, 33'h0);
			period(ch, n);
			chk(33'(n), 33'd400, "gated source");
		end
		$display("Test clock outputs done");
		gate(1, 8'h00, 0, n0);
		gate(1, 8'h05, 0, n);
		chk(33'(n - n0), 33'h5, "gate delay 5");
		gate(1, 8'hff, 0, n);
		chk(33'(n - n0), 33'hff, "gate delay 255");
		gate(0, 8'h28, 10, n);
		chk(33'(n), 33'd400, "gate abort");
		gate(0, 8'h03, 0, n);
		chk(33'(n - n0), 33'h3, "intc gate delay 3");
		$display("Test gating done");
		print_verdict();
	end
endmodule : tb_top
